// >>> rtl/oag_consts.svh
// Purpose: Constants for the operand address generator.
// Assumes: Included by bare name from rtl files.
// Notes: Definitions only.
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH
`define OAG_WR_PREFIX 4'hc
`define OAG_PROT_LO 8'hc0
`define OAG_PTR_LOW_RST 8'hc0
`define OAG_PTR_HIGH_RST 8'hc8
`define OAG_ADDR_RST 8'h00
`define OAG_PC_RST 16'h0000
`define OAG_PC_STEP 16'h0001
`define OAG_ZERO_HI 8'h00
`endif

// >>> rtl/oag_pkg.sv
// Purpose: Types for the operand address generator.
// Assumes: One clock domain.
// Notes: Mode and instruction enumerations.
package oag_pkg;
  typedef enum logic [2:0] {
    OAG_M_REG = 3'h0,
    OAG_M_PTR = 3'h1,
    OAG_M_IDX_RF = 3'h2,
    OAG_M_IDX_SHORT = 3'h3,
    OAG_M_IDX_LONG = 3'h4,
    OAG_M_ABS = 3'h5,
    OAG_M_VEC = 3'h6,
    OAG_M_PCOFF = 3'h7
  } oag_mode_t;
  typedef enum logic [3:0] {
    OAG_I_LOAD_MOVE = 4'h0,
    OAG_I_PROG_LOAD = 4'h1,
    OAG_I_EXT_LOAD = 4'h2,
    OAG_I_ABS_JUMP = 4'h3,
    OAG_I_SUB_INVOKE = 4'h4,
    OAG_I_BTB_FALSE = 4'h5,
    OAG_I_BTB_TRUE = 4'h6,
    OAG_I_DEC_BNZ = 4'h7,
    OAG_I_CIB_EQ = 4'h8,
    OAG_I_CIB_NE = 4'h9,
    OAG_I_SHORT_BR = 4'ha,
    OAG_I_OTHER = 4'hb
  } oag_instr_t;
  typedef enum logic [1:0] {
    OAG_S_RF = 2'h0,
    OAG_S_PROG = 2'h1,
    OAG_S_EXT = 2'h2,
    OAG_S_NONE = 2'h3
  } oag_space_t;
  typedef struct packed {
    oag_mode_t mode;
    oag_instr_t instr;
    logic literal; // Operand is the field itself
    logic wide; // Word operand or pair pointer
    logic [7:0] reg_field; // Register address field
    logic [15:0] imm; // Base, offset, literal or address
  } oag_req_t;
  typedef struct packed {
    logic valid; // Result valid
    logic error; // Mode not allowed or protected target
    oag_space_t space; // Target space
    logic [15:0] addr; // Effective address or value
    logic is_value; // addr holds an operand value
    logic load_pc; // addr goes to the program counter
    logic vec_fetch; // addr is a vector pair to fetch
  } oag_resp_t;
endpackage : oag_pkg

// >>> rtl/oag_wreg_map.sv
// Purpose: Register address field to full register-file address.
// Assumes: Pointers hold the slice base in their five high bits.
// Notes: Combinational.
`timescale 1ns/10ps
`default_nettype none
`include "oag_consts.svh"
module oag_wreg_map
  import oag_pkg::*;
(
  input wire logic [7:0] field, // Register field from instruction
  input wire logic [7:0] ptr_low, // slice_pointer_low
  input wire logic [7:0] ptr_high, // slice_pointer_high
  output logic [7:0] addr // Full register address
);
  logic [7:0] sel;
  always_comb begin
    sel = field[3] ? ptr_high : ptr_low;
    if (field[7:4] == `OAG_WR_PREFIX) begin
      addr = {sel[7:3], field[2:0]};
    end else begin
      addr = field;
    end
  end
endmodule : oag_wreg_map
`default_nettype wire

// >>> rtl/oag_addr_gen.sv
// Purpose: Effective operand address generation, one request per cycle.
// Assumes: Register file read port answers combinationally on rf_addr.
// Notes: Result two cycles after the request; pair reads are even/odd.
`timescale 1ns/10ps
`default_nettype none
`include "oag_consts.svh"
// Overview of operation
// - Register mode yields the content of the named register or pair.
// - Working registers use a pointer selecting an 8-byte slice, then a register.
// - Pointer mode uses register content as address into chosen space.
// - Any register holds a file pointer; any pair holds a memory pointer.
// - Pointer mode may not reach C0H to FFH of set 1.
// - Indexed mode may not reach C0H to FFH of set 1.
// - File indexed address is instruction base plus working register offset.
// - Memory indexed address is working pair base plus 8 or 16-bit offset.
// - Short memory offsets are sign-extended, range -128 to +127.
// - File indexing only for load_move; memory loads index memory.
// - Absolute mode carries 16-bit address; jumps and calls load it into PC.
// - Vector mode only for subroutine_invoke; low 256 bytes, high byte zero.
// - PC offset adds signed displacement to PC of the next instruction.
// - Only the six branch instructions may use pc_offset mode.
// - Literal mode uses the operand field itself, byte or word.
// - Pairs keep the high byte at even address, low byte at odd.
// - Field bit 3 picks pointer; five pointer bits join three field bits.
module oag_addr_gen
  import oag_pkg::*;
(
  input wire logic clk, // 125 MHz core clock
  input wire logic rst, // Synchronous active-high reset
  input wire logic req_valid, // Request strobe
  input wire oag_req_t req, // Request fields
  input wire logic [15:0] pc_next, // PC of following instruction
  input wire logic [7:0] ptr_low_wr, // New slice_pointer_low value
  input wire logic ptr_low_we, // Write strobe for it
  input wire logic [7:0] ptr_high_wr, // New slice_pointer_high value
  input wire logic ptr_high_we, // Write strobe for it
  input wire logic set1_sel, // Upper 64 bytes currently map to set 1
  output logic [7:0] rf_addr, // Register file read address (even for pairs)
  input wire logic [7:0] rf_even, // Data at rf_addr
  input wire logic [7:0] rf_odd, // Data at rf_addr+1
  output var oag_resp_t resp // Registered result
);
  logic [7:0] ptr_low;
  logic [7:0] ptr_high;
  logic [7:0] reg_addr;
  logic [7:0] next_rf_addr;
  oag_resp_t next_resp;

  function automatic logic prot_hit(input logic [7:0] a, input logic s1);
    prot_hit = s1 && (a >= `OAG_PROT_LO);
  endfunction : prot_hit

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction : sext8

  function automatic logic is_mem_load(input oag_instr_t i);
    is_mem_load = (i == OAG_I_PROG_LOAD) || (i == OAG_I_EXT_LOAD);
  endfunction : is_mem_load

  // Carry out of bit 7 is dropped on purpose
  function automatic logic [7:0] idx_sum(input logic [7:0] b, input logic [7:0] o);
    idx_sum = b + o;
  endfunction : idx_sum

  oag_wreg_map u_map (
    .field(req.reg_field),
    .ptr_low(ptr_low),
    .ptr_high(ptr_high),
    .addr(reg_addr)
  );

  // Pointers reset onto the common working area
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_low <= `OAG_PTR_LOW_RST;
    end else if (ptr_low_we) begin
      ptr_low <= ptr_low_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_high <= `OAG_PTR_HIGH_RST;
    end else if (ptr_high_we) begin
      ptr_high <= ptr_high_wr;
    end
  end

  // Pair reads are always aligned; byte reads use the exact address
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_addr <= `OAG_ADDR_RST;
    end else begin
      rf_addr <= next_rf_addr;
    end
  end

  always_comb begin
    next_rf_addr = req.wide ? {reg_addr[7:1], 1'b0} : reg_addr;
  end

  // Register data is read on rf_addr, which is registered from the request, so the data
  // arrives one cycle after the request; to keep request and data together
  // the request is held registered and resolved here.
  oag_req_t held;
  logic held_valid;
  logic [15:0] held_pc;
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= '0;
      held_valid <= 1'b0;
      held_pc <= `OAG_PC_RST;
    end else begin
      held <= req;
      held_valid <= req_valid;
      held_pc <= pc_next;
    end
  end

  logic [15:0] pair;
  always_comb begin
    pair = {rf_even, rf_odd};
    next_resp = '0;
    next_resp.valid = held_valid;
    next_resp.space = OAG_S_NONE;
    case (held.mode)
      OAG_M_REG: begin
        if (held.literal) begin
          next_resp.addr = held.wide ? held.imm : {`OAG_ZERO_HI, held.imm[7:0]};
        end else begin
          next_resp.addr = held.wide ? pair : {`OAG_ZERO_HI, rf_even};
        end
        next_resp.is_value = 1'b1;
      end
      OAG_M_PTR: begin
        if (is_mem_load(held.instr)) begin
          next_resp.space = (held.instr == OAG_I_PROG_LOAD) ? OAG_S_PROG : OAG_S_EXT;
          next_resp.addr = pair;
        end else begin
          next_resp.space = OAG_S_RF;
          next_resp.addr = {`OAG_ZERO_HI, rf_even};
          next_resp.error = prot_hit(rf_even, set1_sel);
        end
      end
      OAG_M_IDX_RF: begin
        next_resp.space = OAG_S_RF;
        next_resp.addr = {`OAG_ZERO_HI, idx_sum(held.imm[7:0], rf_even)};
        next_resp.error = (held.instr != OAG_I_LOAD_MOVE)
          || prot_hit(idx_sum(held.imm[7:0], rf_even), set1_sel);
      end
      OAG_M_IDX_SHORT, OAG_M_IDX_LONG: begin
        next_resp.space = (held.instr == OAG_I_PROG_LOAD) ? OAG_S_PROG : OAG_S_EXT;
        next_resp.addr = pair + ((held.mode == OAG_M_IDX_SHORT) ? sext8(held.imm[7:0]) : held.imm);
        next_resp.error = !is_mem_load(held.instr);
      end
      OAG_M_ABS: begin
        next_resp.addr = held.imm;
        if (held.instr == OAG_I_ABS_JUMP || held.instr == OAG_I_SUB_INVOKE) begin
          next_resp.load_pc = 1'b1;
          next_resp.space = OAG_S_PROG;
        end else begin
          next_resp.space = (held.instr == OAG_I_EXT_LOAD) ? OAG_S_EXT : OAG_S_PROG;
        end
      end
      OAG_M_VEC: begin
        next_resp.space = OAG_S_PROG;
        next_resp.addr = {`OAG_ZERO_HI, held.imm[7:0]};
        next_resp.vec_fetch = 1'b1;
        next_resp.error = (held.instr != OAG_I_SUB_INVOKE);
      end
      OAG_M_PCOFF: begin
        next_resp.space = OAG_S_PROG;
        next_resp.addr = held_pc + sext8(held.imm[7:0]);
        next_resp.load_pc = 1'b1;
        case (held.instr)
          OAG_I_BTB_FALSE, OAG_I_BTB_TRUE, OAG_I_DEC_BNZ, OAG_I_CIB_EQ, OAG_I_CIB_NE,
          OAG_I_SHORT_BR: next_resp.error = 1'b0;
          default: next_resp.error = 1'b1;
        endcase
      end
      default: next_resp.error = 1'b1;
    endcase
    if (next_resp.error) begin
      next_resp.load_pc = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
    end
  end

  property p_pcoff;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_PCOFF && held.instr == OAG_I_SHORT_BR)
      |=> (resp.addr == $past(held_pc) + {{8{$past(held.imm[7])}}, $past(held.imm[7:0])}) && resp.load_pc;
  endproperty
  a_pcoff: assert property (p_pcoff) else $error("pc offset sum wrong");

  property p_pcoff_only;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_PCOFF && held.instr == OAG_I_ABS_JUMP) |=> resp.error && !resp.load_pc;
  endproperty
  a_pcoff_only: assert property (p_pcoff_only) else $error("pc offset allowed for jump");

  property p_vec;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_VEC)
      |=> resp.addr[15:8] == `OAG_ZERO_HI && resp.error == ($past(held.instr) != OAG_I_SUB_INVOKE);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");

  property p_idx_wrap;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_IDX_RF) |=> resp.addr[15:8] == `OAG_ZERO_HI && resp.space == OAG_S_RF
        && resp.addr[7:0] == 8'($past(held.imm[7:0]) + $past(rf_even));
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("indexed file address overflow");

  property p_prot;
    @(posedge clk) disable iff (rst)
      (held_valid && set1_sel && held.mode == OAG_M_IDX_RF && 8'(held.imm[7:0] + rf_even) >= `OAG_PROT_LO)
      |=> resp.error;
  endproperty
  a_prot: assert property (p_prot) else $error("protected area reached by index");

  property p_ptr_prot;
    @(posedge clk) disable iff (rst)
      (held_valid && set1_sel && held.mode == OAG_M_PTR && held.instr == OAG_I_LOAD_MOVE && rf_even >= `OAG_PROT_LO)
      |=> resp.error;
  endproperty
  a_ptr_prot: assert property (p_ptr_prot) else $error("protected area reached by pointer");

  property p_abs;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_ABS && held.instr == OAG_I_ABS_JUMP) |=> resp.load_pc && resp.addr == $past(held.imm);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute jump target wrong");

  property p_short;
    @(posedge clk) disable iff (rst)
      (held_valid && held.mode == OAG_M_IDX_SHORT && held.instr == OAG_I_EXT_LOAD)
      |=> resp.addr == $past(pair) + {{8{$past(held.imm[7])}}, $past(held.imm[7:0])};
  endproperty
  a_short: assert property (p_short) else $error("short offset not sign-extended");

  property p_wreg;
    @(posedge clk) disable iff (rst)
      (req.reg_field[7:4] == `OAG_WR_PREFIX && !req.wide) |=> rf_addr[2:0] == $past(req.reg_field[2:0]);
  endproperty
  a_wreg: assert property (p_wreg) else $error("working register offset wrong");
endmodule : oag_addr_gen
`default_nettype wire

// >>> tb/oag_rf_model.sv
// Purpose: Register file read port seen by the address generator.
// Assumes: Contents follow a fixed pattern, addr xor 5a.
// Notes: Answers combinationally, as the hand-over asks.
`timescale 1ns/10ps
`default_nettype none
module oag_rf_model (
  input wire logic [7:0] rf_addr, // Read address from the generator
  output logic [7:0] rf_even, // Byte at rf_addr
  output logic [7:0] rf_odd // Byte at rf_addr+1
);
  // Pattern keeps every byte distinct, so a wrong address shows up
  assign rf_even = rf_addr ^ 8'h5a;
  assign rf_odd = (rf_addr + 8'h01) ^ 8'h5a;
endmodule : oag_rf_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the operand address generator.
// Assumes: Result stands after the edge that follows the taking edge.
// Notes: Expected values are worked out from the file pattern.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import oag_pkg::*;
;
  logic clk, rst, req_valid, ptr_low_we, ptr_high_we, set1_sel;
  oag_req_t req;
  logic [15:0] pc_next;
  logic [7:0] ptr_low_wr, ptr_high_wr, rf_addr, rf_even, rf_odd;
  oag_resp_t resp;
  int miscompares = 0;
  int tests_run = 0;

  oag_addr_gen DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .pc_next(pc_next),
    .ptr_low_wr(ptr_low_wr), .ptr_low_we(ptr_low_we), .ptr_high_wr(ptr_high_wr),
    .ptr_high_we(ptr_high_we), .set1_sel(set1_sel), .rf_addr(rf_addr), .rf_even(rf_even),
    .rf_odd(rf_odd), .resp(resp));
  oag_rf_model rf (.rf_addr(rf_addr), .rf_even(rf_even), .rf_odd(rf_odd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // pc: 0 or 1 checks load_pc, 2 leaves it unchecked
  task automatic op(input oag_mode_t m, input oag_instr_t i, input logic l, input logic w,
    input logic [7:0] f, input logic [15:0] v, input logic [15:0] ea, input logic ee, input int pc);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req = '{m, i, l, w, f, v};
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    @(posedge clk);
    #1;
    tests_run++;
    if (resp.valid !== 1'b1 || resp.error !== ee || (ee == 1'b0 && resp.addr !== ea) ||
        (pc < 2 && resp.load_pc !== pc[0])) begin
      miscompares++;
      $display("Error resp mode=%0d instr=%0d expected addr=%h err=%b seen addr=%h err=%b pc=%b",
        m, i, ea, ee, resp.addr, resp.error, resp.load_pc);
    end
  endtask : op

  // Result still stands when op returns, so flags are judged right after it
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic t_space();
    op(OAG_M_PTR, OAG_I_EXT_LOAD, 0, 1, 8'h40, 16'h0000, 16'h1a1b, 0, 0);
    chk("space ext", 16'(OAG_S_EXT), 16'(resp.space));
    chk("is_value ptr", 16'h0000, 16'(resp.is_value));
    op(OAG_M_VEC, OAG_I_SUB_INVOKE, 0, 1, 8'h00, 16'h0037, 16'h0037, 0, 2);
    chk("vec_fetch", 16'h0001, 16'(resp.vec_fetch));
    chk("space vec", 16'(OAG_S_PROG), 16'(resp.space));
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 1, 0, 8'h40, 16'h0055, 16'h0055, 0, 0);
    chk("is_value lit", 16'h0001, 16'(resp.is_value));
    op(OAG_M_IDX_RF, OAG_I_LOAD_MOVE, 0, 0, 8'h30, 16'h00f0, 16'h005a, 0, 0);
    chk("space idx", 16'(OAG_S_RF), 16'(resp.space));
    op(OAG_M_PCOFF, OAG_I_SHORT_BR, 0, 0, 8'h00, 16'h0002, 16'h1002, 0, 1);
  endtask : t_space

  task automatic t_register();
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 0, 0, 8'h40, 16'h0000, 16'h001a, 0, 0);
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 0, 1, 8'h40, 16'h0000, 16'h1a1b, 0, 0);
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 1, 1, 8'h40, 16'hbeef, 16'hbeef, 0, 0);
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 1, 0, 8'h40, 16'h12ab, 16'h00ab, 0, 0);
  endtask : t_register

  task automatic t_working();
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 0, 0, 8'hc6, 16'h0000, 16'h009c, 0, 2);
    @(posedge clk);
    #1;
    ptr_high_wr = 8'ha8;
    ptr_high_we = 1'b1;
    ptr_low_wr = 8'h70;
    ptr_low_we = 1'b1;
    @(posedge clk);
    #1;
    ptr_high_we = 1'b0;
    ptr_low_we = 1'b0;
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 0, 0, 8'hcb, 16'h0000, 16'h00f1, 0, 2);
    op(OAG_M_REG, OAG_I_LOAD_MOVE, 0, 0, 8'hc6, 16'h0000, 16'h002c, 0, 2);
  endtask : t_working

  task automatic t_pointer();
    op(OAG_M_PTR, OAG_I_LOAD_MOVE, 0, 0, 8'h40, 16'h0000, 16'h001a, 0, 0);
    op(OAG_M_PTR, OAG_I_PROG_LOAD, 0, 1, 8'h40, 16'h0000, 16'h1a1b, 0, 0);
    op(OAG_M_PTR, OAG_I_LOAD_MOVE, 0, 0, 8'h9a, 16'h0000, 16'h00c0, 0, 0);
    set1_sel = 1'b1;
    op(OAG_M_PTR, OAG_I_LOAD_MOVE, 0, 0, 8'h9a, 16'h0000, 16'h00c0, 1, 0);
    set1_sel = 1'b0;
  endtask : t_pointer

  task automatic t_indexed();
    op(OAG_M_IDX_RF, OAG_I_LOAD_MOVE, 0, 0, 8'h30, 16'h00f0, 16'h005a, 0, 0);
    op(OAG_M_IDX_RF, OAG_I_LOAD_MOVE, 0, 0, 8'h30, 16'h0010, 16'h007a, 0, 0);
    op(OAG_M_IDX_RF, OAG_I_EXT_LOAD, 0, 0, 8'h30, 16'h0010, 16'h0000, 1, 0);
    set1_sel = 1'b1;
    op(OAG_M_IDX_RF, OAG_I_LOAD_MOVE, 0, 0, 8'h30, 16'h0060, 16'h00ca, 1, 0);
    set1_sel = 1'b0;
    op(OAG_M_IDX_SHORT, OAG_I_PROG_LOAD, 0, 1, 8'h40, 16'h0080, 16'h199b, 0, 0);
    op(OAG_M_IDX_SHORT, OAG_I_EXT_LOAD, 0, 1, 8'h40, 16'h007f, 16'h1a9a, 0, 0);
    op(OAG_M_IDX_LONG, OAG_I_EXT_LOAD, 0, 1, 8'h40, 16'hf000, 16'h0a1b, 0, 0);
  endtask : t_indexed

  task automatic t_flow();
    oag_instr_t br[6] = '{OAG_I_BTB_FALSE, OAG_I_BTB_TRUE, OAG_I_DEC_BNZ, OAG_I_CIB_EQ,
      OAG_I_CIB_NE, OAG_I_SHORT_BR};
    op(OAG_M_ABS, OAG_I_ABS_JUMP, 0, 1, 8'h00, 16'h1234, 16'h1234, 0, 1);
    op(OAG_M_ABS, OAG_I_SUB_INVOKE, 0, 1, 8'h00, 16'hfedc, 16'hfedc, 0, 1);
    op(OAG_M_ABS, OAG_I_PROG_LOAD, 0, 1, 8'h00, 16'h4321, 16'h4321, 0, 0);
    op(OAG_M_VEC, OAG_I_SUB_INVOKE, 0, 1, 8'h00, 16'hff37, 16'h0037, 0, 2);
    op(OAG_M_VEC, OAG_I_ABS_JUMP, 0, 1, 8'h00, 16'h0037, 16'h0000, 1, 0);
    pc_next = 16'h1000;
    for (int k = 0; k < 6; k++) begin
      op(OAG_M_PCOFF, br[k], 0, 0, 8'h00, 16'h0080, 16'h0f80, 0, 2);
      op(OAG_M_PCOFF, br[k], 0, 0, 8'h00, 16'h007f, 16'h107f, 0, 2);
    end
    op(OAG_M_PCOFF, OAG_I_LOAD_MOVE, 0, 0, 8'h00, 16'h0010, 16'h0000, 1, 0);
  endtask : t_flow

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pc_next = 16'h0000;
    ptr_low_wr = 8'h00;
    ptr_low_we = 1'b0;
    ptr_high_wr = 8'h00;
    ptr_high_we = 1'b0;
    set1_sel = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tests_run++;
    if (resp !== '0) begin
      miscompares++;
      $display("Error resp after reset expected 0 seen %h", resp);
    end
    t_register();
    t_working();
    t_pointer();
    t_indexed();
    t_flow();
    t_space();
    close_out();
  end

  // Whole run is about 140 cycles; 2000 cycles means a hang
  initial begin
    #16000;
    miscompares++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
